/* logic/pulse_width_capture_timer.sv */
// Purpose: pulse width measurement mode of a 16-bit up-counting timer
// Assumes: byte register port, read data one cycle after the read strobe
// Notes:   capture held in capture_reg_file, pin conditioned in pin_filter
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module pulse_width_capture_timer
   import pwm_capture_pkg::*;
(
   input  wire logic                       clk,
   input  wire logic                       rst,
   input  wire logic                       clkEn,
   input  wire logic                       timerInputPin,
   input  wire logic [ADDR_W-1:0]          addr,
   input  wire logic [7:0]                 wrData,
   input  wire logic                       wrEn,
   input  wire logic                       rdEn,
   output logic      [7:0]                 rdData,
   output logic                            firstTimerInterrupt,
   output logic      [pwm_capture_pkg::CNT_W-1:0] counterValue
);
   import pwm_capture_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // registers and helpers
   capture_if   cif ();
   logic [7:0]  firstTimerControl_reg;
   logic [7:0]  prescale_reg;
   logic [1:0]  status_reg;
   logic [1:0]  mask_reg;
   logic [CNT_W-1:0] count_reg;
   meas_state_t state_reg;
   logic        rdCap_reg;
   logic [ADDR_W-1:0] rdAddr_reg;
   logic [7:0]  capByte;
   logic        capLoad;
   logic        widthEvt;
   logic        periodEvt;
   logic        startEdge;
   logic        stopEdge;
   logic [1:0]  triggerStartSelect;
   logic        captureEdgeMode;
   logic        riseStart;
   logic        running;

   assign triggerStartSelect = firstTimerControl_reg[CTRL_START_HI:CTRL_START_LO];
   assign captureEdgeMode    = firstTimerControl_reg[CTRL_MODE_BIT];
   // 01: start on rising edge, 10: start on falling edge, 00/11: stopped
   assign running   = triggerStartSelect == 2'b01 || triggerStartSelect == 2'b10;
   assign riseStart = triggerStartSelect == 2'b01;
   assign startEdge = riseStart ? cif.edgeRise : cif.edgeFall;
   assign stopEdge  = riseStart ? cif.edgeFall : cif.edgeRise;
   assign cif.prescale = prescale_reg;

   pin_filter u_filter (
      .clk           (clk),
      .rst           (rst),
      .clkEn         (clkEn),
      .timerInputPin (timerInputPin),
      .fo            (cif.filter),
      .dv            (cif.divider)
   );

   ////////////////////////////////////////////////////////////////////////////
   // measurement state machine
   always_comb begin
      widthEvt  = 1'b0;
      periodEvt = 1'b0;
      if (clkEn && running) begin
         unique case (state_reg)
            ST_COUNT: begin
               widthEvt  = stopEdge;
               periodEvt = startEdge && captureEdgeMode;
            end
            ST_WAIT: begin
               periodEvt = startEdge && captureEdgeMode;
            end
            default: begin
               widthEvt  = 1'b0;
            end
         endcase
      end
   end
   assign capLoad = widthEvt || periodEvt;

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= ST_IDLE;
      end else if (clkEn) begin
         if (!running) begin
            state_reg <= ST_IDLE;
         end else begin
            unique case (state_reg)
               ST_IDLE: begin
                  if (startEdge) begin
                     state_reg <= ST_COUNT;
                  end
               end
               ST_COUNT: begin
                  if (widthEvt) begin
                     state_reg <= ST_WAIT;
                  end
               end
               ST_WAIT: begin
                  if (startEdge) begin
                     state_reg <= ST_COUNT;
                  end
               end
               default: begin
                  state_reg <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // counter: idle at 0, counts on ticks, restarts at one on each period capture and, in width mode, on each width capture
   always_ff @(posedge clk) begin
      if (rst) begin
         count_reg <= '0;
      end else if (clkEn) begin
         if (!running) begin
            count_reg <= '0;
         end else if (widthEvt && !captureEdgeMode) begin
            count_reg <= HOLD_ONE;
         end else if (periodEvt) begin
            count_reg <= HOLD_ONE;
         end else if (state_reg == ST_COUNT && cif.tick) begin
            count_reg <= count_reg + 1'b1;
         end else if (state_reg == ST_WAIT && captureEdgeMode && cif.tick) begin
            count_reg <= count_reg + 1'b1;
         end
      end
   end
   assign counterValue = count_reg;

   capture_reg_file u_capture (
      .clk       (clk),
      .rst       (rst),
      .clkEn     (clkEn),
      .load      (capLoad),
      .loadValue (count_reg),
      .rdHigh    (addr == OFS_CAPHI),
      .rdByte    (capByte)
   );

   ////////////////////////////////////////////////////////////////////////////
   // register writes
   always_ff @(posedge clk) begin
      if (rst) begin
         firstTimerControl_reg <= CTRL_RESET;
         prescale_reg          <= PRESC_RESET;
         mask_reg              <= STAT_RESET;
      end else if (clkEn && wrEn) begin
         if (addr == OFS_CTRL) begin
            firstTimerControl_reg <= wrData;
         end
         if (addr == OFS_PRESC) begin
            prescale_reg <= wrData;
         end
         if (addr == OFS_MASK) begin
            mask_reg <= wrData[1:0];
         end
      end
   end

   // sticky events: set wins over write-one-to-clear
   always_ff @(posedge clk) begin
      if (rst) begin
         status_reg <= STAT_RESET;
      end else if (clkEn) begin
         status_reg <= (status_reg & ~((wrEn && addr == OFS_STATUS) ? wrData[1:0] : 2'b00))
                       | {periodEvt, widthEvt};
      end
   end
   assign firstTimerInterrupt = |(status_reg & mask_reg);

   ////////////////////////////////////////////////////////////////////////////
   // register reads: data in the cycle after the strobe only
   always_ff @(posedge clk) begin
      if (rst) begin
         rdCap_reg  <= 1'b0;
         rdAddr_reg <= '0;
      end else if (clkEn) begin
         rdCap_reg  <= rdEn;
         rdAddr_reg <= addr;
      end
   end

   always_comb begin
      rdData = 8'h00;
      if (rdCap_reg) begin
         unique case (rdAddr_reg)
            OFS_CTRL:   rdData = firstTimerControl_reg;
            OFS_CAPLO:  rdData = capByte;
            OFS_CAPHI:  rdData = capByte;
            OFS_STATUS: rdData = {6'h00, status_reg};
            OFS_MASK:   rdData = {6'h00, mask_reg};
            OFS_PRESC:  rdData = prescale_reg;
            default:    rdData = 8'h00;
         endcase
      end
   end
endmodule
`default_nettype wire

/* logic/pwm_capture_pkg.sv */
// Purpose: constants and types for the pulse width capture timer
// Assumes: 100 MHz core clock, byte-wide register port
// Notes:   one package shared by the top and its two helpers
`default_nettype none
package pwm_capture_pkg;
   localparam int unsigned CNT_W        = 16;
   localparam int unsigned ADDR_W       = 3;
   // register offsets
   localparam logic [2:0]  OFS_CTRL     = 3'h0;
   localparam logic [2:0]  OFS_CAPLO    = 3'h1;
   localparam logic [2:0]  OFS_CAPHI    = 3'h2;
   localparam logic [2:0]  OFS_STATUS   = 3'h3;
   localparam logic [2:0]  OFS_MASK     = 3'h4;
   localparam logic [2:0]  OFS_PRESC    = 3'h5;
   // control fields
   localparam int unsigned CTRL_START_LO = 4;
   localparam int unsigned CTRL_START_HI = 5;
   localparam int unsigned CTRL_MODE_BIT = 6;
   localparam logic [7:0]  CTRL_RESET    = 8'h00;
   localparam logic [7:0]  PRESC_RESET   = 8'h00;
   localparam logic [1:0]  STAT_RESET    = 2'h0;
   // status bits
   localparam int unsigned ST_WIDTH     = 0;
   localparam int unsigned ST_PERIOD    = 1;
   // noise filter timing, fc taken as the core clock
   localparam int unsigned CLK_MHZ      = 100;
   localparam int unsigned CORE_MHZ     = 100;
   localparam int unsigned NOISE_FC     = 7;
   localparam int unsigned DETECT_FC    = 13;
   // a level must hold longer than the noise window and is seen by the detect time
   localparam int unsigned FILT_CYC     = (((NOISE_FC + 1) * CLK_MHZ + CORE_MHZ - 1) / CORE_MHZ);
   localparam int unsigned FILT_W       = 4;
   localparam logic [CNT_W-1:0] HOLD_ONE = 16'h0001;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_WAIT  = 2'b01,
      ST_COUNT = 2'b11
   } meas_state_t;
endpackage
`default_nettype wire

/* logic/capture_if.sv */
// Purpose: edge, tick and prescale signals between the timer and its pin filter
// Assumes: one clock domain
// Notes:   modports split filter, divider and core views
`timescale 1ns/1ns
`default_nettype none
interface capture_if;
   import pwm_capture_pkg::*;
   logic             edgeRise;
   logic             edgeFall;
   logic             tick;
   logic [7:0]       prescale;
   modport filter (output edgeRise, output edgeFall);
   modport divider (input prescale, output tick);
   modport core (input edgeRise, input edgeFall, input tick, output prescale);
endinterface
`default_nettype wire

/* logic/pin_filter.sv */
// Purpose: synchronise and filter the timer input pin, give clean edges
// Assumes: pin asynchronous to clk
// Notes:   also holds the source clock divider
`timescale 1ns/1ns
`default_nettype none
module pin_filter
   import pwm_capture_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic clkEn,
   input  wire logic timerInputPin,
   capture_if.filter fo,
   capture_if.divider dv
);
   logic             syncA_reg;
   logic             syncB_reg;
   logic             stable_reg;
   logic [FILT_W-1:0] filtCnt_reg;
   logic [7:0]       div_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         syncA_reg <= 1'b0;
         syncB_reg <= 1'b0;
      end else if (clkEn) begin
         syncA_reg <= timerInputPin;
         syncB_reg <= syncA_reg;
      end
   end

   // level must differ for FILT_CYC cycles before it is accepted
   always_ff @(posedge clk) begin
      if (rst) begin
         stable_reg  <= 1'b0;
         filtCnt_reg <= '0;
      end else if (clkEn) begin
         if (syncB_reg == stable_reg) begin
            filtCnt_reg <= '0;
         end else if (filtCnt_reg == FILT_W'(FILT_CYC - 1)) begin
            stable_reg  <= syncB_reg;
            filtCnt_reg <= '0;
         end else begin
            filtCnt_reg <= filtCnt_reg + 1'b1;
         end
      end
   end

   assign fo.edgeRise = clkEn && (syncB_reg != stable_reg) && syncB_reg
                        && (filtCnt_reg == FILT_W'(FILT_CYC - 1));
   assign fo.edgeFall = clkEn && (syncB_reg != stable_reg) && !syncB_reg
                        && (filtCnt_reg == FILT_W'(FILT_CYC - 1));

   // source clock tick: once every prescale+1 cycles
   always_ff @(posedge clk) begin
      if (rst) begin
         div_reg <= '0;
      end else if (clkEn) begin
         div_reg <= (div_reg >= dv.prescale) ? 8'h00 : div_reg + 8'h01;
      end
   end
   assign dv.tick = clkEn && (div_reg >= dv.prescale);
endmodule
`default_nettype wire

/* logic/capture_reg_file.sv */
// Purpose: 16-bit capture holding register with byte read-out
// Assumes: load and read from the same clock
// Notes:   read data leave a register
`timescale 1ns/1ns
`default_nettype none
module capture_reg_file
   import pwm_capture_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             clkEn,
   input  wire logic             load,
   input  wire logic [CNT_W-1:0] loadValue,
   input  wire logic             rdHigh,
   output logic      [7:0]       rdByte
);
   logic [CNT_W-1:0] cap_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         cap_reg <= '0;
      end else if (clkEn && load) begin
         cap_reg <= loadValue;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdByte <= 8'h00;
      end else if (clkEn) begin
         rdByte <= rdHigh ? cap_reg[15:8] : cap_reg[7:0];
      end
   end
endmodule
`default_nettype wire

/* bench/capture_timer_monitor.sv */
// Purpose: port checks for the pulse width capture timer
// Assumes: sees only the top ports
// Notes:   control kept in a shadow rebuilt from bus writes
`timescale 1ns/1ns
`default_nettype none
module capture_timer_monitor (
   input wire logic                             clk,
   input wire logic                             rst,
   input wire logic                             clkEn,
   input wire logic [pwm_capture_pkg::ADDR_W-1:0] addr,
   input wire logic [7:0]                       wrData,
   input wire logic                             wrEn,
   input wire logic                             rdEn,
   input wire logic [7:0]                       rdData,
   input wire logic                             firstTimerInterrupt,
   input wire logic [pwm_capture_pkg::CNT_W-1:0] counterValue
);
   import pwm_capture_pkg::*;
   logic [7:0] ctrlReg;
   logic [3:0] ageReg;
   ////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrlReg <= CTRL_RESET;
         ageReg  <= 4'h0;
      end else if (wrEn && clkEn && addr == OFS_CTRL) begin
         ctrlReg <= wrData;
         ageReg  <= 4'h0;
      end else if (ageReg != 4'hf) begin
         ageReg  <= ageReg + 4'h1;
      end
   end
   ////////////////////////////////////////
   default clocking dc @(posedge clk); endclocking
   default disable iff (rst);
   rd_idle_zero_a: assert property (!$past(rdEn) |-> rdData == 8'h00)
      else $error("read data not zero outside a read");
   unmapped_read_a: assert property (rdEn && clkEn && addr > OFS_PRESC |=> rdData == 8'h00)
      else $error("unmapped read not zero");
   ctrl_readback_a: assert property (rdEn && clkEn && addr == OFS_CTRL
      |=> rdData[6:4] == ctrlReg[6:4])
      else $error("control fields read back wrong");
   count_step_a: assert property (counterValue > $past(counterValue)
      |-> counterValue == $past(counterValue) + 16'h0001)
      else $error("counter jumped");
   freeze_hold_a: assert property (!clkEn |=> $stable(counterValue))
      else $error("counter moved with clock enable low");
   drop_to_one_a: assert property (ageReg > 4'h3 && ^ctrlReg[5:4]
      && counterValue < $past(counterValue) |-> counterValue == HOLD_ONE)
      else $error("counter not restarted at one");
   stop_clear_a: assert property (ageReg > 4'h3 && !(^ctrlReg[5:4])
      |-> counterValue == 16'h0000)
      else $error("stopped counter not zero");
   irq_masked_a: assert property (wrEn && clkEn && addr == OFS_MASK && wrData[1:0] == 2'h0
      |=> ##1 !firstTimerInterrupt)
      else $error("interrupt high while masked");
   cover property ($rose(firstTimerInterrupt));
   cover property (counterValue == HOLD_ONE && $past(counterValue) > HOLD_ONE);
   cover property (!clkEn && counterValue != 16'h0000);
endmodule
bind pulse_width_capture_timer capture_timer_monitor i_capture_timer_monitor (
   .clk(clk), .rst(rst), .clkEn(clkEn), .addr(addr), .wrData(wrData), .wrEn(wrEn),
   .rdEn(rdEn), .rdData(rdData), .firstTimerInterrupt(firstTimerInterrupt),
   .counterValue(counterValue));
`default_nettype wire

/* bench/pulse_source.sv */
// Purpose: drives the timer input pin with a repeating pulse
// Assumes: lengths in clk cycles, at least one
// Notes:   pin rests low while stopped
`timescale 1ns/1ns
`default_nettype none
module pulse_source (
   input  wire logic       clk,
   input  wire logic       run,
   input  wire logic [7:0] highLen,
   input  wire logic [7:0] lowLen,
   output var  logic       pin
);
   logic [7:0] phase = 8'h01;
   always @(posedge clk) begin
      if (!run) begin
         pin   <= 1'b0;
         phase <= 8'h01;
      end else if (phase >= (pin ? highLen : lowLen)) begin
         pin   <= ~pin;
         phase <= 8'h01;
      end else begin
         phase <= phase + 8'h01;
      end
   end
endmodule
`default_nettype wire

/* bench/tb_pulse_width_capture_timer.sv */
// Purpose: self-checking bench for the pulse width capture timer
// Assumes: random pulse lengths from an lfsr seeded with 35
// Notes:   captures checked within one count of the ideal
`timescale 1ns/1ns
`default_nettype none
module tb_pulse_width_capture_timer;
   import pwm_capture_pkg::*;
   logic clk = 1'b0, rst = 1'b1, clkEn = 1'b1, pin, wrEn = 1'b0, rdEn = 1'b0, irq, run = 1'b0;
   logic [2:0]  addr = 3'h0;
   logic [7:0]  wrData = 8'h00, rdData, highLen = 8'h14, lowLen = 8'h14, lfsr = 8'h23, d;
   logic [15:0] counterValue;
   logic [7:0]  modes [5] = '{8'h10, 8'h20, 8'h50, 8'h60, 8'h10};
   int errors = 0;
   int total_checks = 0;
   always #5 clk = ~clk;
   pulse_width_capture_timer i_pulse_width_capture_timer (.clk(clk), .rst(rst), .clkEn(clkEn),
      .timerInputPin(pin), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
      .rdData(rdData), .firstTimerInterrupt(irq), .counterValue(counterValue));
   pulse_source i_pulse_source (.clk(clk), .run(run), .highLen(highLen), .lowLen(lowLen),
      .pin(pin));
   ////////////////////////////////////////
   function automatic logic [7:0] lfsrNext(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [15:0] expCount(input logic [15:0] cyc, input logic [7:0] p);
      return cyc / (16'(p) + 16'h0001) + 16'h0001;
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wrData <= v;
      wrEn <= 1'b1;
      @(posedge clk);
      wrEn <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rdEn <= 1'b1;
      @(posedge clk);
      rdEn <= 1'b0;
      @(negedge clk);
      v = rdData;
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   task automatic measure(input logic [7:0] ctrl, input logic [7:0] p);
      logic [7:0]  st, lo, hi;
      logic [15:0] c, last, e;
      int          n;
      run <= 1'b0;
      repeat (20) @(posedge clk);
      lfsr = lfsrNext(lfsr);
      highLen <= 8'h14 + {2'b00, lfsr[5:0]};
      lfsr = lfsrNext(lfsr);
      lowLen <= 8'h14 + {2'b00, lfsr[5:0]};
      // stop first so each run starts from idle with a cleared count and state
      wr(OFS_CTRL, 8'h00);
      wr(OFS_PRESC, p);
      wr(OFS_CTRL, ctrl);
      wr(OFS_MASK, 8'h03);
      wr(OFS_STATUS, 8'h03);
      run <= 1'b1;
      last = 16'h0000;
      for (int i = 0; i < 5; i++) begin
         n = 0;
         // poll mid-cycle so the status clear written just before has settled
         do begin
            @(negedge clk);
            n++;
         end while (irq !== 1'b1 && n < 3000);
         chk(16'(irq), 16'h0001);
         rd(OFS_STATUS, st);
         rd(OFS_CAPLO, lo);
         rd(OFS_CAPHI, hi);
         c = {hi, lo};
         wr(OFS_STATUS, st);
         chk(16'(st), (ctrl[6] && i[0]) ? 16'h0002 : 16'h0001);
         if (st[1]) e = expCount(16'(highLen) + 16'(lowLen), p);
         else e = expCount(16'(ctrl[5] ? lowLen : highLen), p);
         if (i > 1) chk(16'(c + 16'h0001 >= e && c <= e + 16'h0001), 16'h0001);
         if (i > 2 && p == 8'h00 && !ctrl[6]) chk(c, last);
         last = c;
      end
      run <= 1'b0;
      $display("test measure %h done", ctrl);
   endtask
   ////////////////////////////////////////
   initial begin
      #200000;
      errors++;
      final_report();
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 8; a++) begin
         if (a == 1 || a == 2) continue;
         rd(3'(a), d);
         chk(16'(d), 16'h0000);
      end
      wr(3'h7, 8'hff);
      rd(OFS_CTRL, d);
      chk(16'(d), 16'h0000);
      wr(OFS_CTRL, 8'h50);
      rd(OFS_CTRL, d);
      chk(16'(d & 8'h70), 16'h0050);
      $display("test registers done");
      wr(OFS_MASK, 8'h00);
      wr(OFS_CTRL, 8'h10);
      highLen <= 8'h07;
      lowLen <= 8'h28;
      run <= 1'b1;
      repeat (300) @(posedge clk);
      rd(OFS_STATUS, d);
      chk(16'(d), 16'h0000);
      chk(counterValue, 16'h0000);
      highLen <= 8'h0d;
      repeat (300) @(posedge clk);
      clkEn <= 1'b0;
      rd(OFS_CTRL, d);
      chk(16'(d), 16'h0000);
      repeat (20) @(posedge clk);
      clkEn <= 1'b1;
      run <= 1'b0;
      repeat (30) @(posedge clk);
      rd(OFS_STATUS, d);
      chk(16'(d[0]), 16'h0001);
      chk(16'(irq), 16'h0000);
      wr(OFS_MASK, 8'h01);
      repeat (2) @(negedge clk);
      chk(16'(irq), 16'h0001);
      wr(OFS_STATUS, 8'h01);
      repeat (2) @(negedge clk);
      chk(16'(irq), 16'h0000);
      $display("test noise and interrupt done");
      for (int m = 0; m < 5; m++) begin
         lfsr = lfsrNext(lfsr);
         measure(modes[m], (m == 4) ? {6'h00, lfsr[1:0]} | 8'h01 : 8'h00);
      end
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(OFS_STATUS, d);
      chk(16'(d), 16'h0000);
      chk(counterValue, 16'h0000);
      $display("test second reset done");
      final_report();
   end
endmodule
`default_nettype wire
